// *** ocpl_pkg.sv ***
// constants, register map and state type of the overcurrent protection latch
// assumes a 20 MHz system clock and a 1 us protection tick
package ocpl_pkg;
  localparam int NCH = 4;
  localparam int AW  = 8;

  localparam logic [7:0] ADR_ONREQ  = 8'h00;
  localparam logic [7:0] ADR_CTRL   = 8'h04;
  localparam logic [7:0] ADR_FAULT  = 8'h08;
  localparam logic [7:0] ADR_MASK   = 8'h0c;
  localparam logic [7:0] ADR_STATE  = 8'h10;

  localparam int CTRL_CLR_BIT  = 0;
  localparam int STATE_ON_LSB  = 0;
  localparam int STATE_LAT_LSB = 4;
  localparam int STATE_SHD_LSB = 8;

  localparam logic [3:0] ONREQ_RST = 4'h0;
  localparam logic [3:0] MASK_RST  = 4'h0;
  localparam logic [3:0] FAULT_RST = 4'h0;

  localparam int CLK_HZ       = 20_000_000;
  localparam int TICK_NS      = 1000;
  localparam int TICK_CYC     = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
  localparam int TURNON_US    = 100;
  localparam int RESTART_US   = 200;
  localparam int TURNON_TK    = TURNON_US * 1000 / TICK_NS;
  localparam int RESTART_TK   = RESTART_US * 1000 / TICK_NS;
  localparam int TW           = 9;

  localparam int RW = 4;
  localparam logic [RW-1:0] RETRY_LIM [0:3] = '{4'h7, 4'h3, 4'h1, 4'h0};

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_COOL, ST_LATCH} ocpl_st_t;
endpackage

// *** ocpl_tick.sv ***
// divider giving a one-cycle enable pulse every DIV clocks
// assumes a single synchronous clock and active-high sync reset
`timescale 1ns/1ns
module ocpl_tick #(
  parameter int DIV = 20
) (
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // sync reset, high
  output logic      tick_o  // one-cycle enable
);
  logic [15:0] cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (cnt == 16'(DIV - 1))
    begin
      cnt    <= 16'h0000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt    <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// *** ocpl_top.sv ***
// overcurrent protection latch for four high-side channels, wishbone slave
// assumes comparator inputs synchronous to clk_i, classic wishbone master
//
// Notes on behaviour
// - a channel that is on is switched off when its load current passes the trip level.
// - after an overcurrent shutdown the channel restarts by itself a limited number of times.
// - the restart limit is picked from the channel's drain-source voltage band.
// - once the limit is used up the channel stays latched off.
// - over temperature during restart cycling latches the channel off.
// - the fault flag is set while the channel is held off by overcurrent shutdown.
// - reading the fault flag clears it, except while shutdown persists, when the set wins and it stays set.
// - after an automatic restart a read clears the flag until a new trip sets it.
// - writing one to latch_clear_command releases a retry or temperature latch.
// - a cleared latch turns the channel on at once if pin or on-request bit is set.
// - overcurrent at high drain voltage during turn-on latches off at once, no restarts.
// - writing one to latch_clear_command also frees the high-voltage latch.
`timescale 1ns/1ns
module ocpl_top #(
  parameter int NCH = ocpl_pkg::NCH
) (
  input  wire logic             clk_i,        // 20 MHz clock
  input  wire logic             rst_i,        // sync reset, high
  input  wire logic [7:0]       wb_adr_i,     // byte address
  input  wire logic [31:0]      wb_dat_i,     // write data
  output logic      [31:0]      wb_dat_o,     // read data
  input  wire logic             wb_we_i,      // write enable
  input  wire logic [3:0]       wb_sel_i,     // byte lanes
  input  wire logic             wb_stb_i,     // strobe
  input  wire logic             wb_cyc_i,     // cycle
  output logic                  wb_ack_o,     // acknowledge
  input  wire logic [NCH-1:0]   in_pin_i,     // channel input pins
  input  wire logic [NCH-1:0]   over_cur_i,   // current above trip level
  input  wire logic [NCH-1:0]   vds_high_i,   // vds above drain_voltage_threshold
  input  wire logic [2*NCH-1:0] vds_band_i,   // vds band per channel
  input  wire logic [NCH-1:0]   over_temp_i,  // at thermal_shutdown_temperature
  output logic      [NCH-1:0]   chan_on_o,    // channel switch drive
  output logic                  irq_o         // unmasked fault pending
);
  logic           ack;
  logic           acc;
  logic           wr;
  logic           rd;
  logic [NCH-1:0] channel_on_request_bits;
  logic           latch_clear_command;
  logic [NCH-1:0] fault;
  logic [NCH-1:0] mask;
  logic [NCH-1:0] shut_v;
  logic [NCH-1:0] lat_v;
  logic [NCH-1:0] on_v;
  logic [NCH-1:0] next_fault;
  logic           rd_fault;
  logic           tick;

  assign acc      = wb_cyc_i & wb_stb_i & ~ack;
  assign wr       = acc & wb_we_i & wb_sel_i[0];
  assign rd       = acc & ~wb_we_i;
  assign rd_fault = rd & (wb_adr_i == ocpl_pkg::ADR_FAULT);
  assign wb_ack_o = ack;
  assign chan_on_o = on_v;

  ocpl_tick #(
    .DIV (ocpl_pkg::TICK_CYC)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= acc;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
    begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        ocpl_pkg::ADR_ONREQ: wb_dat_o[NCH-1:0] <= channel_on_request_bits;
        ocpl_pkg::ADR_FAULT: wb_dat_o[NCH-1:0] <= fault;
        ocpl_pkg::ADR_MASK:  wb_dat_o[NCH-1:0] <= mask;
        ocpl_pkg::ADR_STATE:
        begin
          wb_dat_o[ocpl_pkg::STATE_ON_LSB +: NCH]  <= on_v;
          wb_dat_o[ocpl_pkg::STATE_LAT_LSB +: NCH] <= lat_v;
          wb_dat_o[ocpl_pkg::STATE_SHD_LSB +: NCH] <= shut_v;
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel_on_request_bits <= ocpl_pkg::ONREQ_RST;
      mask                    <= ocpl_pkg::MASK_RST;
    end
    else if (wr)
    begin
      if (wb_adr_i == ocpl_pkg::ADR_ONREQ)
        channel_on_request_bits <= wb_dat_i[NCH-1:0];
      if (wb_adr_i == ocpl_pkg::ADR_MASK)
        mask <= wb_dat_i[NCH-1:0];
    end
  end

  // self-clearing command pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      latch_clear_command <= 1'b0;
    else
      latch_clear_command <= wr & (wb_adr_i == ocpl_pkg::ADR_CTRL)
                             & wb_dat_i[ocpl_pkg::CTRL_CLR_BIT];
  end

  // set wins over the read clear
  always_comb
  begin
    next_fault = (rd_fault ? '0 : fault) | shut_v;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault <= ocpl_pkg::FAULT_RST;
    else
      fault <= next_fault;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(fault & mask);
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      localparam int TWL = ocpl_pkg::TW;
      localparam int RWL = ocpl_pkg::RW;

      ocpl_pkg::ocpl_st_t    st;
      logic [TWL-1:0]        tmr;
      logic [RWL-1:0]        rcnt;
      logic [RWL-1:0]        lim;
      logic                  req_now;
      logic                  req_d;
      logic                  in_win;

      assign req_now   = in_pin_i[i] | channel_on_request_bits[i];
      assign lim       = ocpl_pkg::RETRY_LIM[vds_band_i[2*i +: 2]];
      assign in_win    = tmr < TWL'(ocpl_pkg::TURNON_TK);
      assign on_v[i]   = (st == ocpl_pkg::ST_ON);
      assign lat_v[i]  = (st == ocpl_pkg::ST_LATCH);
      assign shut_v[i] = (st == ocpl_pkg::ST_COOL) | lat_v[i];

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          req_d <= 1'b0;
        else
          req_d <= req_now;
      end

      // per-channel state, independent of neighbours
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          st  <= ocpl_pkg::ST_OFF;
          tmr <= '0;
        end
        else
        begin
          case (st)
            ocpl_pkg::ST_OFF:
            begin
              tmr <= '0;
              if (req_now)
                st <= ocpl_pkg::ST_ON;
            end
            ocpl_pkg::ST_ON:
            begin
              if (tick && in_win)
                tmr <= tmr + TWL'(1);
              if (!req_now)
                st <= ocpl_pkg::ST_OFF;
              else if (over_cur_i[i])
              begin
                tmr <= '0;
                if (vds_high_i[i] && in_win)
                  st <= ocpl_pkg::ST_LATCH;
                else if (rcnt >= lim)
                  st <= ocpl_pkg::ST_LATCH;
                else
                  st <= ocpl_pkg::ST_COOL;
              end
            end
            ocpl_pkg::ST_COOL:
            begin
              if (tick)
                tmr <= tmr + TWL'(1);
              if (over_temp_i[i])
                st <= ocpl_pkg::ST_LATCH;
              else if (tmr == TWL'(ocpl_pkg::RESTART_TK))
              begin
                tmr <= '0;
                st  <= req_now ? ocpl_pkg::ST_ON : ocpl_pkg::ST_OFF;
              end
            end
            ocpl_pkg::ST_LATCH:
            begin
              tmr <= '0;
              if (latch_clear_command)
                st <= req_now ? ocpl_pkg::ST_ON : ocpl_pkg::ST_OFF;
            end
            default: st <= ocpl_pkg::ST_OFF;
          endcase
        end
      end

      // restart count, reset by a fresh on-request while not latched
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          rcnt <= '0;
        else if (st == ocpl_pkg::ST_LATCH)
        begin
          if (latch_clear_command)
            rcnt <= '0;
        end
        else if (st == ocpl_pkg::ST_ON && req_now && over_cur_i[i]
                 && !(vds_high_i[i] && in_win) && rcnt < lim)
          rcnt <= rcnt + RWL'(1);
        else if (req_now && !req_d)
          rcnt <= '0;
      end

      sequence trip_s;
        on_v[i] && req_now && over_cur_i[i];
      endsequence

      sequence clear_s;
        lat_v[i] && latch_clear_command;
      endsequence

      oc_off_a: assert property (trip_s |=> !on_v[i])
        else $error("channel stayed on after overcurrent");

      restart_a: assert property (st == ocpl_pkg::ST_COOL && !over_temp_i[i]
        && tmr == TWL'(ocpl_pkg::RESTART_TK) && req_now |=> on_v[i])
        else $error("no restart after cool-down");

      limit_hit_a: assert property (trip_s and (rcnt >= lim)
        |=> lat_v[i])
        else $error("restart limit not enforced");

      latch_hold_a: assert property (lat_v[i] && !latch_clear_command
        |=> lat_v[i] && !on_v[i])
        else $error("latch released without clear");

      temp_latch_a: assert property (st == ocpl_pkg::ST_COOL
        && over_temp_i[i] |=> lat_v[i])
        else $error("over temperature did not latch");

      shut_flag_a: assert property (shut_v[i] |=> fault[i])
        else $error("fault flag missing in shutdown");

      read_clr_a: assert property (rd_fault && !shut_v[i]
        |=> !fault[i] ##1 !fault[i] || shut_v[i])
        else $error("fault flag not cleared by read");

      new_trip_a: assert property (on_v[i] && !fault[i] && !over_cur_i[i]
        |=> !fault[i])
        else $error("fault flag set without new trip");

      clear_on_a: assert property (clear_s and req_now |=> on_v[i])
        else $error("cleared channel not turned on");

      clear_off_a: assert property (clear_s and !req_now
        |=> st == ocpl_pkg::ST_OFF)
        else $error("latch not released by clear");

      hv_latch_a: assert property (trip_s and (vds_high_i[i] && in_win)
        |=> lat_v[i] ##1 (lat_v[i] || $past(latch_clear_command)))
        else $error("high vds trip did not latch");
    end
  endgenerate

  irq_gate_a: assert property ((fault & mask) == '0 ##1 (fault & mask) == '0
    |-> !irq_o)
    else $error("interrupt without unmasked fault");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// *** ocpl_host.sv ***
// wishbone host model issuing classic single cycles for the bench
// assumes a slave that answers with a registered one-cycle ack
`timescale 1ns/1ns
module ocpl_host #(
  parameter int CLR_WAIT = 40  // latch_clear_wait_time in clocks, plain default
) (
  input  wire logic        clk_i,  // system clock
  input  wire logic        ack_i,  // slave acknowledge
  input  wire logic [31:0] dat_i,  // read data
  output logic      [7:0]  adr_o,  // byte address
  output logic      [31:0] dat_o,  // write data
  output logic             we_o,   // write enable
  output logic      [3:0]  sel_o,  // byte lanes
  output logic             stb_o,  // strobe
  output logic             cyc_o   // cycle
);
  initial
  begin
    {adr_o, dat_o, we_o, sel_o, stb_o, cyc_o} = '0;
  end

  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'b11, we, 4'hf, adr, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 50);
    rd = dat_i;
    ok = (ack_i === 1'b1);
    // released address and data lines show the inverse; we_o and sel_o keep the old value
    {cyc_o, stb_o, adr_o, dat_o} <= {2'b00, ~adr, ~wd};
  endtask

  task automatic clear(output logic ok);
    logic [31:0] rd;
    repeat (CLR_WAIT) @(posedge clk_i);
    xfer(1'b1, ocpl_pkg::ADR_CTRL, 32'h1 << ocpl_pkg::CTRL_CLR_BIT, rd, ok);
  endtask
endmodule

// *** tb.sv ***
// self-checking bench for the overcurrent protection latch
// assumes ocpl_pkg, ocpl_top and ocpl_host are compiled before it
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        we;
  logic        stb;
  logic        cyc;
  logic        ack;
  logic [3:0]  sel;
  logic [3:0]  in_pin = '0;
  logic [3:0]  ocur   = '0;
  logic [3:0]  vhigh  = '0;
  logic [3:0]  otemp  = '0;
  logic [3:0]  on;
  logic [7:0]  band   = 8'hc2;
  logic        irq;
  logic        ok;
  logic [31:0] v;
  logic [31:0] r;
  logic [31:0] seed   = 32'd4477;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #25 clk_i = ~clk_i;

  ocpl_top ocpl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc),
    .wb_ack_o(ack), .in_pin_i(in_pin), .over_cur_i(ocur), .vds_high_i(vhigh),
    .vds_band_i(band), .over_temp_i(otemp), .chan_on_o(on), .irq_o(irq));
  ocpl_host ocpl_host_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .adr_o(adr),
    .dat_o(wdat), .we_o(we), .sel_o(sel), .stb_o(stb), .cyc_o(cyc));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] st_word(logic [3:0] o, logic [3:0] lat, logic [3:0] shd);
    return {20'h0, shd, lat, o};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    ocpl_host_inst.xfer(w, a, d, v, ok);
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  task automatic rdchk(string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    `CHK(nm, ex, v)
  endtask

  task automatic trip(int ch);
    @(posedge clk_i);
    ocur[ch] <= 1'b1;
    @(posedge clk_i);
    ocur[ch] <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("state", ocpl_pkg::ADR_STATE, st_word(4'h0, 4'h0, 4'h0));
    rdchk("unmapped", 8'h20, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      bus(1'b1, ocpl_pkg::ADR_ONREQ, r);
      repeat (2) @(posedge clk_i);
      `CHK("on", r[3:0], on)
      rdchk("onreq", ocpl_pkg::ADR_ONREQ, {28'h0, r[3:0]});
    end
    $display("test random on requests done");
    bus(1'b1, ocpl_pkg::ADR_MASK, 32'h1);
    rdchk("mask", ocpl_pkg::ADR_MASK, 32'h1);
    bus(1'b1, ocpl_pkg::ADR_ONREQ, 32'hd);
    trip(0);
    `CHK("on", 4'hc, on)
    rdchk("fault", ocpl_pkg::ADR_FAULT, 32'h1);
    `CHK("irq", 1'b1, irq)
    rdchk("fault", ocpl_pkg::ADR_FAULT, 32'h1);
    for (int n = 0; n < 5000 && on[0] !== 1'b1; n++)
      @(posedge clk_i);
    `CHK("restart", 1'b1, on[0])
    rdchk("fault", ocpl_pkg::ADR_FAULT, 32'h1);
    rdchk("fault", ocpl_pkg::ADR_FAULT, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b0, irq)
    $display("test restart done");
    trip(0);
    rdchk("state", ocpl_pkg::ADR_STATE, st_word(4'hc, 4'h1, 4'h1));
    repeat (4500) @(posedge clk_i);
    `CHK("latched", 1'b0, on[0])
    trip(3);
    trip(2);
    otemp[2] <= 1'b1;
    @(posedge clk_i);
    otemp[2] <= 1'b0;
    in_pin[1] <= 1'b1;
    vhigh[1]  <= 1'b1;
    repeat (3) @(posedge clk_i);
    trip(1);
    rdchk("state", ocpl_pkg::ADR_STATE, st_word(4'h0, 4'hf, 4'hf));
    `CHK("on", 4'h0, on)
    $display("test latches done");
    ocpl_host_inst.clear(ok);
    `CHK("clear ack", 1'b1, ok)
    repeat (2) @(posedge clk_i);
    `CHK("on", 4'hf, on)
    rdchk("state", ocpl_pkg::ADR_STATE, st_word(4'hf, 4'h0, 4'h0));
    rdchk("fault", ocpl_pkg::ADR_FAULT, 32'hf);
    rdchk("fault", ocpl_pkg::ADR_FAULT, 32'h0);
    $display("test clear done");
    give_verdict();
  end
endmodule
